// File: logic/scd_top.sv
// State code decode, bus qualifiers and clock generation glue
`default_nettype none
module scd_top
  import scd_pkg::*;
#(
  parameter int unsigned POR_CYCLES = SCD_POR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SCD_MIB_W-1:0] microword,
  input wire logic syncIn,
  input wire logic dataInStrobe,
  input wire logic dataOutStrobe,
  input wire logic writeOrByteIn,
  input wire logic ioSelect,
  input wire logic replyHandshakeIn,
  input wire logic extMasterGrantIn,
  input wire logic rtcRequestIn,
  input wire logic [3:1] vecLevelIn,
  input wire logic vecReadStrobe,
  input wire logic [SCD_STAT_W-1:0] statusData,
  input wire logic waitFromData,
  output logic [15:1] decodedCodeLines,
  output logic rmwByteStrobe,
  output logic rmwWordStrobe,
  output logic extStatusRequest,
  output logic bootAddrRequest,
  output logic vectorIrqEnable,
  output logic statusGate,
  output logic [1:0] opSelect,
  output logic coreResetN,
  output logic transferStart,
  output logic writeOpFlag,
  output logic writeOrByteLatched,
  output logic ioOutputCycle,
  output logic replyToCore,
  output logic ctrlBufferEnable,
  output logic extMasterGrantDup,
  output logic rtcIrqToCore,
  output logic [SCD_DAL_W-1:0] dalOut,
  output logic [SCD_DAL_W-1:0] dalOe,
  output logic runEnable,
  output logic busPhase1,
  output logic busPhase2,
  output logic masterDividedClock,
  output logic [3:0] corePhases
);
  // Two-flop synchronisers for every pin input
  localparam int SYN_W = 14 + SCD_STAT_W;
  logic [SYN_W-1:0] syncA_reg;
  logic [SYN_W-1:0] syncB_reg;
  wire [SYN_W-1:0] pinsRaw = {statusData, waitFromData, vecReadStrobe, vecLevelIn,
    rtcRequestIn, extMasterGrantIn, replyHandshakeIn, ioSelect, writeOrByteIn,
    dataOutStrobe, dataInStrobe, syncIn, 1'b0};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= pinsRaw;
      syncB_reg <= syncA_reg;
    end
  end
  wire sSync = syncB_reg[1];
  wire sDin = syncB_reg[2];
  wire sDout = syncB_reg[3];
  wire sWb = syncB_reg[4];
  wire sIoSel = syncB_reg[5];
  wire sReply = syncB_reg[6];
  wire sGrant = syncB_reg[7];
  wire sRtc = syncB_reg[8];
  wire [3:1] sVec = syncB_reg[11:9];
  wire sVecRd = syncB_reg[12];
  wire sWait = syncB_reg[13];
  wire [SCD_STAT_W-1:0] sStatus = syncB_reg[SYN_W-1:14];

  // Code field is same-domain from the core microword latch
  wire [SCD_CODE_W-1:0] codeField = microword[SCD_CODE_LSB +: SCD_CODE_W];
  logic [15:1] codeLines;
  scd_code_decoder u_dec (
    .code(codeField),
    .codeLines(codeLines)
  );

  function automatic logic hit(input logic [15:1] lines, input logic [3:0] c);
    hit = lines[c];
  endfunction : hit

  wire scRmwByte = hit(codeLines, SCD_SC_RMW_BYTE) | hit(codeLines, SCD_SC_RMW_BYTE2);
  wire scRmwWord = hit(codeLines, SCD_SC_RMW_WORD) | hit(codeLines, SCD_SC_RMW_WORD2);
  wire scStatus = hit(codeLines, SCD_SC_STATUS);
  wire scBoot = hit(codeLines, SCD_SC_BOOT);
  wire scIrqEn = hit(codeLines, SCD_SC_IRQ_EN);
  wire scIrqDis = hit(codeLines, SCD_SC_IRQ_DIS);
  wire [1:0] opNext = (scRmwByte | scRmwWord) ? SCD_OP_RMW :
    (sWb ? SCD_OP_WRITE : SCD_OP_READ);

  // Clock divider: fractional tick on each 4 MHz source edge, halved to 2 MHz
  logic [23:0] srcAcc_reg;
  logic srcTick_reg;
  logic srcClk_reg;
  logic half_reg;
  scd_phase_e phase_reg;
  wire [24:0] srcSum = {1'b0, srcAcc_reg} + 25'(2 * SCD_SRC_HZ);
  wire srcWrap = (srcSum >= 25'(SCD_CLK_HZ));
  wire [24:0] srcRem = srcSum - 25'(SCD_CLK_HZ);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srcAcc_reg <= '0;
      srcTick_reg <= 1'b0;
    end else begin
      srcAcc_reg <= srcWrap ? srcRem[23:0] : srcSum[23:0];
      srcTick_reg <= srcWrap;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      srcClk_reg <= 1'b0;
      half_reg <= 1'b0;
    end else if (srcTick_reg) begin
      srcClk_reg <= ~srcClk_reg;
      if (!srcClk_reg) begin
        half_reg <= ~half_reg;
      end
    end
  end
  // Four phase steps in each 2 MHz period
  wire phaseStep = srcTick_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg <= SCD_PH1;
    end else if (phaseStep) begin
      unique case (phase_reg)
        SCD_PH1: phase_reg <= SCD_PH2;
        SCD_PH2: phase_reg <= SCD_PH3;
        SCD_PH3: phase_reg <= SCD_PH4;
        SCD_PH4: phase_reg <= SCD_PH1;
      endcase
    end
  end
  // Interrupt enable (irqEn_reg) advances once per 2 MHz phase-1 slot
  wire phaseEn = phaseStep & (phase_reg == SCD_PH1);

  // Power-up hold of the core
  logic [15:0] porCnt_reg;
  wire porDone = (porCnt_reg == 16'(POR_CYCLES));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      porCnt_reg <= '0;
    end else if (!porDone) begin
      porCnt_reg <= porCnt_reg + 16'h0001;
    end
  end

  // Qualifier state
  logic inWrite_reg;
  logic syncPrev_reg;
  logic doutPrev_reg;
  logic irqEn_reg;
  wire syncRise = sSync & ~syncPrev_reg;
  wire doutRise = sDout & ~doutPrev_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncPrev_reg <= 1'b0;
      doutPrev_reg <= 1'b0;
    end else begin
      syncPrev_reg <= sSync;
      doutPrev_reg <= sDout;
    end
  end
  wire inWrite_next = syncRise ? sWb : (sReply && !sSync ? 1'b0 : inWrite_reg);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      inWrite_reg <= 1'b0;
    end else begin
      inWrite_reg <= inWrite_next;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqEn_reg <= 1'b0;
    end else if (phaseEn && scIrqEn) begin
      irqEn_reg <= 1'b1;
    end else if (phaseEn && scIrqDis) begin
      irqEn_reg <= 1'b0;
    end
  end

  wire driveVec = sVecRd & irqEn_reg;
  wire [SCD_DAL_W-1:0] vecBus = SCD_DAL_W'({sVec, 1'b0});
  wire [SCD_DAL_W-1:0] statBus = SCD_DAL_W'(sStatus);
  wire [SCD_DAL_W-1:0] dalNext = driveVec ? vecBus : (scStatus ? statBus : '0);
  wire [SCD_DAL_W-1:0] dalOeNext = driveVec ? SCD_DAL_W'(4'he) :
    (scStatus ? SCD_DAL_W'(8'hff) : '0);

  // Registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      decodedCodeLines <= '0;
      rmwByteStrobe <= 1'b0;
      rmwWordStrobe <= 1'b0;
      extStatusRequest <= 1'b0;
      bootAddrRequest <= 1'b0;
      statusGate <= 1'b0;
      opSelect <= SCD_OP_READ;
      coreResetN <= 1'b0;
      transferStart <= 1'b0;
      writeOpFlag <= 1'b0;
      writeOrByteLatched <= 1'b0;
      ioOutputCycle <= 1'b0;
      replyToCore <= 1'b0;
      ctrlBufferEnable <= 1'b0;
      extMasterGrantDup <= 1'b0;
      rtcIrqToCore <= 1'b0;
      dalOut <= '0;
      dalOe <= '0;
      runEnable <= 1'b0;
      vectorIrqEnable <= 1'b0;
    end else begin
      decodedCodeLines <= codeLines;
      rmwByteStrobe <= scRmwByte;
      rmwWordStrobe <= scRmwWord;
      extStatusRequest <= scStatus;
      bootAddrRequest <= scBoot;
      statusGate <= scStatus;
      opSelect <= opNext;
      coreResetN <= porDone;
      transferStart <= syncRise;
      writeOpFlag <= inWrite_next;
      if (doutRise) begin
        writeOrByteLatched <= sWb;
      end
      ioOutputCycle <= inWrite_next & sIoSel;
      replyToCore <= sReply;
      ctrlBufferEnable <= ~sGrant;
      extMasterGrantDup <= sGrant;
      rtcIrqToCore <= sRtc;
      dalOut <= dalNext;
      dalOe <= dalOeNext;
      runEnable <= ~sWait & porDone;
      vectorIrqEnable <= irqEn_reg;
    end
  end

  // Clock outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busPhase1 <= 1'b0;
      busPhase2 <= 1'b0;
      masterDividedClock <= 1'b0;
      corePhases <= '0;
    end else begin
      busPhase1 <= half_reg;
      busPhase2 <= ~half_reg;
      masterDividedClock <= half_reg;
      corePhases <= 4'h1 << phase_reg;
    end
  end
  wire unusedIn = sDin | syncB_reg[0];
endmodule : scd_top
`default_nettype wire

// File: shared/scd_pkg.sv
// Constants and types for the state code decoder and clocking block
`default_nettype none
package scd_pkg;
  localparam int unsigned SCD_CLK_HZ = 10_000_000;
  localparam int unsigned SCD_SRC_HZ = 4_000_000;
  localparam int unsigned SCD_PHASE_HZ = 2_000_000;
  // Half period of the 4 MHz source in clk cycles, rounded down, at least one
  localparam int unsigned SCD_SRC_HALF_RAW = SCD_CLK_HZ / (2 * SCD_SRC_HZ);
  localparam int unsigned SCD_SRC_HALF = (SCD_SRC_HALF_RAW < 1) ? 1 : SCD_SRC_HALF_RAW;
  localparam int unsigned SCD_POR_US = 10;
  localparam int unsigned SCD_POR_CYC = (SCD_POR_US * (SCD_CLK_HZ / 1_000_000));
  localparam int SCD_CODE_W = 4;
  localparam int SCD_MIB_W = 22;
  localparam int SCD_CODE_LSB = 18;
  localparam int SCD_DAL_W = 16;
  localparam int SCD_VEC_LSB = 1;
  localparam int SCD_STAT_W = 8;
  localparam logic [3:0] SCD_SC_PMSK = 4'h1;
  localparam logic [3:0] SCD_SC_FETCH = 4'h2;
  localparam logic [3:0] SCD_SC_IRQ_EN = 4'h4;
  localparam logic [3:0] SCD_SC_IRQ_DIS = 4'h5;
  localparam logic [3:0] SCD_SC_STATUS = 4'h6;
  localparam logic [3:0] SCD_SC_RDBYTE = 4'h8;
  localparam logic [3:0] SCD_SC_RMW_WORD = 4'h9;
  localparam logic [3:0] SCD_SC_RMW_BYTE = 4'ha;
  localparam logic [3:0] SCD_SC_RTC_CLR = 4'hb;
  localparam logic [3:0] SCD_SC_BOOT = 4'hc;
  localparam logic [3:0] SCD_SC_RDBYTE2 = 4'hd;
  localparam logic [3:0] SCD_SC_RMW_WORD2 = 4'he;
  localparam logic [3:0] SCD_SC_RMW_BYTE2 = 4'hf;
  localparam logic [1:0] SCD_OP_WRITE = 2'h1;
  localparam logic [1:0] SCD_OP_READ = 2'h0;
  localparam logic [1:0] SCD_OP_RMW = 2'h2;
  typedef enum logic [1:0] {SCD_PH1, SCD_PH2, SCD_PH3, SCD_PH4} scd_phase_e;
endpackage : scd_pkg
`default_nettype wire

// File: logic/scd_code_decoder.sv
// One-hot decoder of the microword state code field
`default_nettype none
module scd_code_decoder
  import scd_pkg::*;
(
  input wire logic [SCD_CODE_W-1:0] code,
  output logic [15:1] codeLines
);
  genvar i;
  generate
    for (i = 1; i < 16; i++) begin : g_line
      assign codeLines[i] = (code == SCD_CODE_W'(i));
    end
  endgenerate
endmodule : scd_code_decoder
`default_nettype wire

// File: dv/scd_chk.sv
// Assertions on the decode and glue outputs
`default_nettype none
module scd_chk
  import scd_pkg::*;
#(
  parameter int unsigned POR_CYCLES = SCD_POR_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SCD_MIB_W-1:0] microword,
  input wire logic syncIn,
  input wire logic ioSelect,
  input wire logic extMasterGrantIn,
  input wire logic [15:1] decodedCodeLines,
  input wire logic rmwByteStrobe,
  input wire logic rmwWordStrobe,
  input wire logic bootAddrRequest,
  input wire logic statusGate,
  input wire logic extStatusRequest,
  input wire logic [1:0] opSelect,
  input wire logic coreResetN,
  input wire logic transferStart,
  input wire logic writeOpFlag,
  input wire logic ioOutputCycle,
  input wire logic ctrlBufferEnable,
  input wire logic extMasterGrantDup
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PorHi = POR_CYCLES + 4;
  wire logic [3:0] code;
  assign code = microword[SCD_CODE_LSB+:SCD_CODE_W];
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_code(logic [3:0] c); code == c; endsequence
  sequence s_syncRise; $rose(syncIn); endsequence
  sequence s_pulse; transferStart ##1 !transferStart; endsequence
  property p_rmw_byte_strobe; s_code(4'ha) |=> rmwByteStrobe && !rmwWordStrobe; endproperty
  property p_rmw_word_strobe; s_code(4'h9) |=> rmwWordStrobe && !rmwByteStrobe; endproperty
  property p_dec;
    !$past(rst) |-> decodedCodeLines ==
      (($past(code) == 4'h0) ? 15'h0 : (15'h1 << ($past(code) - 4'h1)));
  endproperty
  property p_stat; s_code(4'h6) |=> statusGate && extStatusRequest; endproperty
  property p_boot; s_code(4'hc) |=> bootAddrRequest && !statusGate; endproperty
  property p_op; (rmwByteStrobe || rmwWordStrobe) |-> opSelect == SCD_OP_RMW; endproperty
  property p_start; s_syncRise |-> ##[2:4] s_pulse; endproperty
  property p_io; ioOutputCycle == (writeOpFlag && $past(ioSelect, 3)); endproperty
  property p_buf;
    $past(extMasterGrantIn, 3) |-> !ctrlBufferEnable && extMasterGrantDup;
  endproperty
  property p_por; $fell(rst) |-> !coreResetN ##[1:PorHi] coreResetN; endproperty
  a_rmw_byte_strobe: assert property (p_rmw_byte_strobe) else $error("rmw byte strobe missing");
  a_rmw_word_strobe: assert property (p_rmw_word_strobe) else $error("rmw word strobe missing");
  a_dec: assert property (p_dec) else $error("code lines wrong");
  a_stat: assert property (p_stat) else $error("status request missing");
  a_boot: assert property (p_boot) else $error("boot request missing");
  a_op: assert property (p_op) else $error("operation select wrong");
  a_start: assert property (p_start) else $error("transfer start wrong");
  a_io: assert property (p_io) else $error("io output cycle wrong");
  a_buf: assert property (p_buf) else $error("buffers on during grant");
  a_por: assert property (p_por) else $error("core reset timing wrong");
endmodule : scd_chk
bind scd_top scd_chk #(.POR_CYCLES(POR_CYCLES)) u_scd_chk (.clk, .rst, .microword, .syncIn,
  .ioSelect, .extMasterGrantIn,
  .decodedCodeLines, .rmwByteStrobe, .rmwWordStrobe, .bootAddrRequest, .statusGate,
  .extStatusRequest, .opSelect, .coreResetN, .transferStart, .writeOpFlag, .ioOutputCycle,
  .ctrlBufferEnable, .extMasterGrantDup);
`default_nettype wire

// File: dv/scd_slave_model.sv
// Bus slave model answering data strobes with reply
`default_nettype none
module scd_slave_model (
  input wire logic clk,
  input wire logic strobe,
  input wire logic [3:0] lag,
  output logic reply
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  initial cnt = 4'h0;
  initial reply = 1'b0;
  // Reply after lag cycles of strobe, drop with it
  always @(posedge clk) begin
    cnt <= strobe ? cnt + 4'h1 : 4'h0;
    reply <= strobe && (cnt >= lag);
  end
endmodule : scd_slave_model
`default_nettype wire

// File: dv/tb_scd_top.sv
// Self-checking bench for the decode and glue block
`default_nettype none
module tb_scd_top
  import scd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, syncIn, dataInStrobe, dataOutStrobe, writeOrByteIn, ioSelect;
  logic replyHandshakeIn, extMasterGrantIn, rtcRequestIn, vecReadStrobe, waitFromData;
  logic [SCD_MIB_W-1:0] microword;
  logic [3:1] vecLevelIn;
  logic [7:0] statusData;
  logic [3:0] lag, corePhases;
  logic [15:1] decodedCodeLines;
  logic [1:0] opSelect;
  logic [15:0] dalOut, dalOe;
  logic rmwByteStrobe, rmwWordStrobe, extStatusRequest, bootAddrRequest, vectorIrqEnable;
  logic statusGate, coreResetN, transferStart, writeOpFlag, writeOrByteLatched;
  logic ioOutputCycle, replyToCore, ctrlBufferEnable, extMasterGrantDup, rtcIrqToCore;
  logic runEnable, busPhase1, busPhase2, masterDividedClock;
  int mismatches = 0;
  int samples_checked = 0;
  scd_top #(.POR_CYCLES(4)) u_scd_top (.clk, .rst, .microword, .syncIn, .dataInStrobe,
    .dataOutStrobe, .writeOrByteIn, .ioSelect, .replyHandshakeIn, .extMasterGrantIn,
    .rtcRequestIn, .vecLevelIn, .vecReadStrobe, .statusData, .waitFromData,
    .decodedCodeLines, .rmwByteStrobe, .rmwWordStrobe, .extStatusRequest, .bootAddrRequest,
    .vectorIrqEnable, .statusGate, .opSelect, .coreResetN, .transferStart, .writeOpFlag,
    .writeOrByteLatched, .ioOutputCycle, .replyToCore, .ctrlBufferEnable,
    .extMasterGrantDup, .rtcIrqToCore, .dalOut, .dalOe, .runEnable, .busPhase1,
    .busPhase2, .masterDividedClock, .corePhases);
  scd_slave_model u_scd_slave_model (.clk, .strobe(dataInStrobe | dataOutStrobe), .lag,
    .reply(replyHandshakeIn));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic setCode(input logic [3:0] c, input int n);
    microword[SCD_CODE_LSB+:SCD_CODE_W] = c;
    step(n);
  endtask : setCode
  task automatic t_codes;
    logic [3:0] c;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      setCode(c, 2);
      chk("lines", decodedCodeLines, (c == 4'h0) ? 16'h0 : 16'h1 << (c - 4'h1));
      chk("rmw_byte_strobe", rmwByteStrobe, c == 4'ha || c == 4'hf);
      chk("rmw_word_strobe", rmwWordStrobe, c == 4'h9 || c == 4'he);
      chk("stat", statusGate, c == 4'h6);
      chk("esr", extStatusRequest, c == 4'h6);
      chk("boot", bootAddrRequest, c == 4'hc);
      chk("op", opSelect, (c == 4'h9 || c == 4'ha || c == 4'he || c == 4'hf) ?
        SCD_OP_RMW : SCD_OP_READ);
    end
    setCode(4'h0, 1);
    $display("test codes done");
  endtask : t_codes
  task automatic t_vec;
    vecLevelIn = 3'h5;
    setCode(4'h4, 8);
    vecReadStrobe = 1'b1;
    setCode(4'h0, 4);
    chk("ien", vectorIrqEnable, 1'b1);
    chk("vdata", dalOut, 16'h000a);
    chk("voe", dalOe, 16'h000e);
    setCode(4'h5, 8);
    setCode(4'h0, 2);
    chk("ien", vectorIrqEnable, 1'b0);
    chk("voe", dalOe, 16'h0000);
    vecReadStrobe = 1'b0;
    statusData = 8'h5a;
    setCode(4'h6, 4);
    chk("sdata", dalOut, 16'h005a);
    chk("soe", dalOe, 16'h00ff);
    setCode(4'h0, 2);
    $display("test vector done");
  endtask : t_vec
  task automatic t_bus(input logic wr, input logic [3:0] lg);
    int n;
    lag = lg;
    writeOrByteIn = wr;
    ioSelect = 1'b1;
    syncIn = 1'b1;
    step(3);
    chk("start", transferStart, 1'b1);
    step(1);
    chk("start", transferStart, 1'b0);
    chk("wop", writeOpFlag, wr);
    chk("iout", ioOutputCycle, wr);
    chk("opsel", opSelect, wr ? SCD_OP_WRITE : SCD_OP_READ);
    writeOrByteIn = lg[0];
    dataOutStrobe = wr;
    dataInStrobe = !wr;
    syncIn = 1'b0;
    n = 0;
    while (replyToCore !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk("reply_handshake", replyToCore, 1'b1);
    if (wr) chk("wbl", writeOrByteLatched, lg[0]);
    dataOutStrobe = 1'b0;
    dataInStrobe = 1'b0;
    step(4);
    chk("wopclr", writeOpFlag, 1'b0);
    chk("iout", ioOutputCycle, 1'b0);
    $display("test bus done");
  endtask : t_bus
  task automatic t_misc(input logic v);
    extMasterGrantIn = v;
    rtcRequestIn = v;
    waitFromData = v;
    step(4);
    chk("buf", ctrlBufferEnable, !v);
    chk("dup", extMasterGrantDup, v);
    chk("rtc", rtcIrqToCore, v);
    chk("run", runEnable, !v);
    $display("test misc done");
  endtask : t_misc
  task automatic t_clk;
    int rises;
    logic prev;
    rises = 0;
    prev = masterDividedClock;
    repeat (100) begin
      step(1);
      if (masterDividedClock === 1'b1 && prev === 1'b0) rises++;
      prev = masterDividedClock;
      chk("phase", $onehot(corePhases), 16'h1);
      chk("bus2", busPhase2, !busPhase1);
      chk("bus1", busPhase1, masterDividedClock);
    end
    chk("mclk", 16'(rises), 16'(100 * SCD_PHASE_HZ / SCD_CLK_HZ));
    $display("test clocks done");
  endtask : t_clk
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {syncIn, dataInStrobe, dataOutStrobe, writeOrByteIn, ioSelect} = '0;
    {extMasterGrantIn, rtcRequestIn, vecReadStrobe, waitFromData} = '0;
    microword = '0;
    vecLevelIn = 3'h0;
    statusData = 8'h00;
    lag = 4'h0;
    step(16);
    rst = 1'b0;
    step(1);
    chk("por", coreResetN, 1'b0);
    step(8);
    chk("por", coreResetN, 1'b1);
    t_codes;
    t_vec;
    t_bus(1'b1, 4'h5);
    t_bus(1'b1, 4'h0);
    t_bus(1'b0, 4'h3);
    t_misc(1'b1);
    t_misc(1'b0);
    t_clk;
    stop_test;
  end
  // Hang guard, well beyond the expected run
  initial begin
    #2_000_000;
    mismatches++;
    stop_test;
  end
endmodule : tb_scd_top
`default_nettype wire
